// File: inc/pfl_pkg.sv
// How it works
// R01 - Command 0x20 makes next data the lock value
// R02 - Zero bits program locks, ones keep them
// R03 - Pulse write low, wait ready before next
// R04 - Locks return unprogrammed only by chip erase
// R05 - Command 0x04 reads fuses, locks while enabled
// R06 - Byte selects pick fuse low, high, extended, lock
// R07 - Programmed fuse or lock bit reads zero
// R08 - Drive data only with enable low, release fast
// R09 - Command 0x08, address picks signature byte 0-2
// R10 - Select one high reads calibration byte 0-3
// R11 - Busy goes low within 1 us of write
// R12 - Writes hold busy 3.7 to 4.5 ms
// R13 - Chip erase holds busy 7.5 to 9 ms
// R14 - Serial download only while reset held low
// R15 - Serial program needs enable instruction first
// R16 - Serial port uses clock, data in, data out
// R17 - Command byte held until next command load
package pfl_pkg;

  localparam logic [7:0] CMD_NOP        = 8'h00;
  localparam logic [7:0] CMD_LOCK_WRITE = 8'h20;
  localparam logic [7:0] CMD_FUSE_READ  = 8'h04;
  localparam logic [7:0] CMD_SIG_READ   = 8'h08;
  localparam logic [7:0] CMD_FUSE_WRITE = 8'h40;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;

  localparam logic [1:0] XA_ADDR = 2'h0;
  localparam logic [1:0] XA_DATA = 2'h1;
  localparam logic [1:0] XA_CMD  = 2'h2;

  localparam logic [7:0] BYTE_ERASED = 8'hff;
  localparam logic [7:0] LOCK_RESET  = 8'hff;
  localparam logic [7:0] SER_EN_BYTE1    = 8'hac;
  localparam logic [7:0] SER_EN_BYTE2    = 8'h53;
  localparam logic [7:0] SER_ERASE_BYTE2 = 8'h80;
  localparam int unsigned SIG_COUNT = 3;
  localparam int unsigned CAL_COUNT = 4;

  // Synchroniser idle: load strobe low, write and enables high, bus floating high
  localparam logic [17:0] PIN_IDLE = 18'h01ffc;

  localparam int unsigned CLK_NS         = 4;
  localparam int unsigned T_WLRH_MIN_NS  = 3700000;
  localparam int unsigned T_WLRH_MAX_NS  = 4500000;
  localparam int unsigned T_ERASE_MIN_NS = 7500000;
  localparam int unsigned T_ERASE_MAX_NS = 9000000;
  localparam int unsigned T_WLRL_MAX_NS  = 1000;
  localparam int unsigned T_PHASE_NS     = 200;
  localparam int unsigned T_DATA_NS      = 250;

  localparam int unsigned WRITE_CYC = (T_WLRH_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned ERASE_CYC = (T_ERASE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WLRL_CYC  = T_WLRL_MAX_NS / CLK_NS;
  localparam int unsigned PHASE_CYC = (T_PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned DATA_CYC  = (T_DATA_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned BUSY_W    = 21;
  localparam int unsigned TIMER_W   = 9;

  typedef enum logic [2:0] {
    PFL_OP_LOCK_WRITE,
    PFL_OP_FUSE_WRITE,
    PFL_OP_CHIP_ERASE,
    PFL_OP_FUSE_READ,
    PFL_OP_SIG_READ,
    PFL_OP_CAL_READ
  } pfl_op_t;

endpackage

// File: inc/pfl_if.sv
`timescale 1ns/100ps
interface pfl_if;
  import pfl_pkg::*;
  logic       load_strobe;
  logic [1:0] load_select;
  logic       byte_select_one;
  logic       byte_select_two;
  logic       oe_n;
  logic       wr_n;
  logic [7:0] prg_data;
  logic       prg_data_oe_n;
  logic [7:0] dev_data;
  logic       dev_data_oe_n;
  logic [7:0] data;
  logic       ready_busy_n;
  logic       serial_reset_n;
  logic       sck;
  logic       serial_prog_in;
  logic       serial_prog_out;

  // Undriven bus floats high
  assign data = !dev_data_oe_n ? dev_data :
                (!prg_data_oe_n ? prg_data : BYTE_ERASED);

  modport dev (
    input  load_strobe, load_select, byte_select_one, byte_select_two,
    input  oe_n, wr_n, data, serial_reset_n, sck, serial_prog_in,
    output dev_data, dev_data_oe_n, ready_busy_n, serial_prog_out
  );
  modport prg (
    input  data, ready_busy_n, serial_prog_out,
    output load_strobe, load_select, byte_select_one, byte_select_two,
    output oe_n, wr_n, prg_data, prg_data_oe_n, serial_reset_n, sck,
    output serial_prog_in
  );
endinterface

// File: core/pfl_device.sv
`timescale 1ns/100ps
module pfl_device #(
  parameter int unsigned WRITE_CYCLES   = pfl_pkg::WRITE_CYC,
  parameter int unsigned ERASE_CYCLES   = pfl_pkg::ERASE_CYC,
  parameter logic [7:0]  FUSE_LOW_INIT  = 8'hff,
  parameter logic [7:0]  FUSE_HIGH_INIT = 8'hff,
  parameter logic [7:0]  FUSE_EXT_INIT  = 8'hff,
  // Arbitrary identity values
  parameter logic [23:0] SIGNATURE      = 24'h030201,
  parameter logic [31:0] CALIBRATION    = 32'h80808080
) (
  input  wire logic clock_in,
  input  wire logic srst_in,
  pfl_if.dev        pins,
  output logic [7:0] lock_bits_out,
  output logic [7:0] fuse_low_out,
  output logic [7:0] fuse_high_out,
  output logic [7:0] fuse_ext_out,
  output logic       busy_out,
  output logic       serial_enabled_out
);
  import pfl_pkg::*;

  if (WRITE_CYCLES < 1 || WRITE_CYCLES >= 2 ** BUSY_W ||
      ERASE_CYCLES < 1 || ERASE_CYCLES >= 2 ** BUSY_W)
  begin : g_bad_cycles
    $error("pfl_device: busy cycle counts out of range");
  end

  logic [17:0]       pin_raw;
  logic [17:0]       pin_meta;
  logic [17:0]       pin_sync;
  logic [17:0]       pin_prev;
  logic              strobe_rise;
  logic [1:0]        xa_s;
  logic              bs1_s;
  logic              bs2_s;
  logic              oe_n_s;
  logic              wr_fall;
  logic [7:0]        data_s;
  logic              rst_n_s;
  logic              sck_rise;
  logic              sck_fall;
  logic              mosi_s;
  logic [7:0]        command;
  logic [7:0]        addr_low;
  logic [7:0]        data_low;
  logic              busy;
  logic              rdy_n;
  logic [BUSY_W-1:0] busy_count;
  logic              start_write;
  logic              start_erase;
  logic [7:0]        next_data;
  logic [7:0]        data_drv;
  logic              data_drv_n;
  logic [31:0]       ser_shift;
  logic [31:0]       ser_word;
  logic [4:0]        ser_bits;
  logic [7:0]        ser_out;
  logic              ser_enabled;
  logic              ser_erase_req;

  assign pin_raw = {pins.load_strobe, pins.load_select, pins.byte_select_one,
                    pins.byte_select_two, pins.oe_n, pins.wr_n, pins.data,
                    pins.serial_reset_n, pins.sck, pins.serial_prog_in};

  // Every pin crosses two flops; the second is decoded, a third gives edges
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      pin_meta <= PIN_IDLE;
      pin_sync <= PIN_IDLE;
      pin_prev <= PIN_IDLE;
    end
    else
    begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign strobe_rise = pin_sync[17] & ~pin_prev[17];
  assign xa_s        = pin_sync[16:15];
  assign bs1_s       = pin_sync[14];
  assign bs2_s       = pin_sync[13];
  assign oe_n_s      = pin_sync[12];
  assign wr_fall     = ~pin_sync[11] & pin_prev[11];
  assign data_s      = pin_sync[10:3];
  assign rst_n_s     = pin_sync[2];
  assign sck_rise    = pin_sync[1] & ~pin_prev[1];
  assign sck_fall    = ~pin_sync[1] & pin_prev[1];
  assign mosi_s      = pin_sync[0];

  // Loads ignored while busy so a write keeps its operands
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      command  <= CMD_NOP;
      addr_low <= 8'h00;
      data_low <= BYTE_ERASED;
    end
    else if (strobe_rise && !busy)
    begin
      case (xa_s)
        XA_CMD:  command <= data_s; // R01 R05 R09 R17
        XA_ADDR:
        begin
          if (!bs1_s)
            addr_low <= data_s; // R09 R10
        end
        XA_DATA:
        begin
          if (!bs1_s)
            data_low <= data_s; // R01
        end
        default: ;
      endcase
    end
  end

  assign start_write = wr_fall && !busy &&
                       (command == CMD_LOCK_WRITE || command == CMD_FUSE_WRITE);
  assign start_erase = !busy &&
                       ((wr_fall && command == CMD_CHIP_ERASE) || ser_erase_req);

  // Busy drops three cycles after the pin edge, far inside 1 us
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      busy       <= 1'b0;
      rdy_n      <= 1'b1;
      busy_count <= '0;
    end
    else if (start_erase)
    begin
      busy       <= 1'b1; // R11
      rdy_n      <= 1'b0; // R11
      busy_count <= BUSY_W'(ERASE_CYCLES - 1); // R13
    end
    else if (start_write)
    begin
      busy       <= 1'b1; // R11
      rdy_n      <= 1'b0; // R11
      busy_count <= BUSY_W'(WRITE_CYCLES - 1); // R12
    end
    else if (busy)
    begin
      if (busy_count == '0)
      begin
        busy  <= 1'b0; // R12 R13
        rdy_n <= 1'b1; // R12 R13
      end
      else
        busy_count <= busy_count - 1'b1;
    end
  end

  // Stored bytes keep zero as programmed, so reads need no inversion
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      lock_bits_out <= LOCK_RESET;
      fuse_low_out  <= FUSE_LOW_INIT;
      fuse_high_out <= FUSE_HIGH_INIT;
      fuse_ext_out  <= FUSE_EXT_INIT;
    end
    else if (start_erase)
      lock_bits_out <= BYTE_ERASED; // R04
    else if (start_write)
    begin
      if (command == CMD_LOCK_WRITE)
        lock_bits_out <= lock_bits_out & data_low; // R02 R04
      else if (bs2_s)
        fuse_ext_out <= data_low;
      else if (bs1_s)
        fuse_high_out <= data_low;
      else
        fuse_low_out <= data_low;
    end
  end

  function automatic logic [7:0] read_byte(
    input logic [7:0] cmd,
    input logic       sel_one,
    input logic       sel_two,
    input logic [7:0] addr
  );
    logic [7:0] result;
    result = BYTE_ERASED;
    if (cmd == CMD_FUSE_READ)
    begin
      case ({sel_two, sel_one})
        2'h0:    result = fuse_low_out; // R06 R07
        2'h3:    result = fuse_high_out; // R06 R07
        2'h2:    result = fuse_ext_out; // R06 R07
        default: result = lock_bits_out; // R06 R07
      endcase
    end
    else if (cmd == CMD_SIG_READ)
    begin
      if (!sel_one && addr < 8'(SIG_COUNT))
        result = SIGNATURE[addr[1:0]*8 +: 8]; // R09
      else if (sel_one && addr < 8'(CAL_COUNT))
        result = CALIBRATION[addr[1:0]*8 +: 8]; // R10
    end
    return result;
  endfunction

  always_comb next_data = read_byte(command, bs1_s, bs2_s, addr_low);

  // Drive follows the enable three cycles late, well under 250 ns
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      data_drv_n <= 1'b1;
      data_drv   <= BYTE_ERASED;
    end
    else
    begin
      data_drv_n <= oe_n_s; // R08
      data_drv   <= next_data; // R05
    end
  end

  assign ser_word = {ser_shift[30:0], mosi_s};

  // Session state is wiped whenever reset goes high
  always_ff @(posedge clock_in)
  begin
    if (srst_in || rst_n_s) // R14
    begin
      ser_shift     <= '0;
      ser_bits      <= '0;
      ser_out       <= 8'h00;
      ser_enabled   <= 1'b0; // R15
      ser_erase_req <= 1'b0;
    end
    else
    begin
      ser_erase_req <= 1'b0;
      if (sck_rise)
      begin
        ser_shift <= ser_word; // R16
        ser_bits  <= ser_bits + 1'b1;
        if (ser_bits == 5'h0f)
          ser_out <= ser_word[7:0];
        if (ser_bits == 5'h1f)
        begin
          if (ser_word[31:24] == SER_EN_BYTE1 && ser_word[23:16] == SER_EN_BYTE2)
            ser_enabled <= 1'b1; // R15
          else if (ser_enabled && ser_word[31:24] == SER_EN_BYTE1 &&
                   ser_word[23:16] == SER_ERASE_BYTE2)
            ser_erase_req <= 1'b1; // R15
        end
      end
      else if (sck_fall && ser_bits[4:3] == 2'h2 && ser_bits[2:0] != 3'h0)
        ser_out <= {ser_out[6:0], 1'b0}; // R16
    end
  end

  assign pins.dev_data        = data_drv;
  assign pins.dev_data_oe_n   = data_drv_n;
  assign pins.ready_busy_n    = rdy_n;
  assign pins.serial_prog_out = ser_out[7];
  assign busy_out             = busy;
  assign serial_enabled_out   = ser_enabled;

endmodule // pfl_device

// File: core/pfl_programmer.sv
`timescale 1ns/100ps
module pfl_programmer (
  input  wire logic     clock_in,
  input  wire logic     srst_in,
  pfl_if.prg            pins,
  input  wire logic     req_valid_in,
  input  pfl_pkg::pfl_op_t req_op_in,
  input  wire logic [7:0] req_addr_in,
  input  wire logic [7:0] req_data_in,
  input  wire logic [1:0] req_sel_in,
  output logic          req_ready_out,
  output logic          done_out,
  output logic [7:0]    rd_data_out,
  input  wire logic     serial_session_in,
  input  wire logic     sck_user_in,
  input  wire logic     mosi_user_in,
  output logic          miso_out
);
  import pfl_pkg::*;

  typedef enum logic [3:0] {
    P_IDLE, P_SETUP, P_STROBE, P_GAP, P_WRITE, P_SETTLE, P_POLL, P_READ, P_RELEASE
  } pfl_pstate_t;

  pfl_pstate_t        state;
  pfl_op_t            op;
  logic [7:0]         addr;
  logic [7:0]         wdata;
  logic [1:0]         sel;
  logic [1:0]         step;
  logic [TIMER_W-1:0] timer;
  logic [9:0]         in_meta;
  logic [9:0]         in_sync;
  logic               strobe;
  logic [1:0]         xa;
  logic               bs1;
  logic               bs2;
  logic               oe_n;
  logic               wr_n;
  logic [7:0]         drv;
  logic               drv_n;
  logic               rst_n;
  logic               sck;
  logic               mosi;

  function automatic logic [7:0] cmd_of(input pfl_op_t o);
    case (o)
      PFL_OP_LOCK_WRITE: return CMD_LOCK_WRITE; // R01
      PFL_OP_FUSE_WRITE: return CMD_FUSE_WRITE;
      PFL_OP_CHIP_ERASE: return CMD_CHIP_ERASE;
      PFL_OP_FUSE_READ:  return CMD_FUSE_READ; // R05
      default:           return CMD_SIG_READ; // R09
    endcase
  endfunction

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      in_meta <= 10'h3ff;
      in_sync <= 10'h3ff;
    end
    else
    begin
      in_meta <= {pins.ready_busy_n, pins.serial_prog_out, pins.data};
      in_sync <= in_meta;
    end
  end

  // One timed phase per state except idle and poll; timer counts down to zero
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      state <= P_IDLE;
      op <= PFL_OP_FUSE_READ;
      addr <= 8'h00;
      wdata <= BYTE_ERASED;
      sel <= 2'h0;
      step <= 2'h0;
      timer <= '0;
      strobe <= 1'b0;
      xa <= XA_CMD;
      bs1 <= 1'b0;
      bs2 <= 1'b0;
      oe_n <= 1'b1;
      wr_n <= 1'b1;
      drv <= BYTE_ERASED;
      drv_n <= 1'b1;
      req_ready_out <= 1'b1;
      done_out <= 1'b0;
      rd_data_out <= 8'h00;
    end
    else
    begin
      done_out <= 1'b0;
      if (timer != '0)
        timer <= timer - 1'b1;
      case (state)
        P_IDLE:
        begin
          if (req_valid_in)
          begin
            op <= req_op_in;
            addr <= req_addr_in;
            wdata <= req_data_in;
            sel <= req_sel_in;
            step <= 2'h0;
            req_ready_out <= 1'b0;
            xa <= XA_CMD;
            bs1 <= 1'b0;
            bs2 <= 1'b0;
            drv <= cmd_of(req_op_in);
            drv_n <= 1'b0;
            timer <= TIMER_W'(PHASE_CYC - 1);
            state <= P_SETUP;
          end
        end
        P_SETUP:
        begin
          if (timer == '0)
          begin
            strobe <= 1'b1;
            timer <= TIMER_W'(PHASE_CYC - 1);
            state <= P_STROBE;
          end
        end
        P_STROBE:
        begin
          if (timer == '0)
          begin
            strobe <= 1'b0;
            timer <= TIMER_W'(PHASE_CYC - 1);
            state <= P_GAP;
          end
        end
        P_GAP:
        begin
          if (timer == '0)
          begin
            timer <= TIMER_W'(PHASE_CYC - 1);
            if (step == 2'h0 && (op == PFL_OP_SIG_READ || op == PFL_OP_CAL_READ))
            begin
              step <= 2'h1;
              xa <= XA_ADDR;
              drv <= addr; // R09 R10
              state <= P_SETUP;
            end
            else if (step == 2'h0 && (op == PFL_OP_LOCK_WRITE || op == PFL_OP_FUSE_WRITE))
            begin
              step <= 2'h2;
              xa <= XA_DATA;
              drv <= wdata; // R01
              state <= P_SETUP;
            end
            else if (op == PFL_OP_LOCK_WRITE || op == PFL_OP_FUSE_WRITE ||
                     op == PFL_OP_CHIP_ERASE)
            begin
              drv_n <= 1'b1;
              bs1 <= (op == PFL_OP_FUSE_WRITE) ? sel[0] : 1'b0;
              bs2 <= (op == PFL_OP_FUSE_WRITE) ? sel[1] : 1'b0;
              wr_n <= 1'b0; // R03
              state <= P_WRITE;
            end
            else
            begin
              drv_n <= 1'b1;
              bs1 <= (op == PFL_OP_FUSE_READ) ? sel[0] : (op == PFL_OP_CAL_READ);
              bs2 <= (op == PFL_OP_FUSE_READ) ? sel[1] : 1'b0; // R06
              oe_n <= 1'b0; // R05
              timer <= TIMER_W'(DATA_CYC + 4);
              state <= P_READ;
            end
          end
        end
        P_WRITE:
        begin
          if (timer == '0)
          begin
            wr_n <= 1'b1;
            timer <= TIMER_W'(WLRL_CYC - 1);
            state <= P_SETTLE;
          end
        end
        P_SETTLE:
        begin
          if (timer == '0)
            state <= P_POLL;
        end
        P_POLL:
        begin
          if (in_sync[9]) // R03
          begin
            done_out <= 1'b1;
            req_ready_out <= 1'b1;
            state <= P_IDLE;
          end
        end
        P_READ:
        begin
          if (timer == '0)
          begin
            rd_data_out <= in_sync[7:0];
            oe_n <= 1'b1; // R08
            timer <= TIMER_W'(DATA_CYC + 4);
            state <= P_RELEASE;
          end
        end
        P_RELEASE:
        begin
          if (timer == '0)
          begin
            done_out <= 1'b1;
            req_ready_out <= 1'b1;
            state <= P_IDLE;
          end
        end
        default: state <= P_IDLE;
      endcase
    end
  end

  // Serial lines pass through; reset pin held low for the whole session
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      rst_n <= 1'b1;
      sck <= 1'b0;
      mosi <= 1'b0;
      miso_out <= 1'b0;
    end
    else
    begin
      rst_n <= ~serial_session_in; // R14
      sck <= serial_session_in & sck_user_in; // R16
      mosi <= serial_session_in & mosi_user_in;
      miso_out <= in_sync[8];
    end
  end

  assign pins.load_strobe     = strobe;
  assign pins.load_select     = xa;
  assign pins.byte_select_one = bs1;
  assign pins.byte_select_two = bs2;
  assign pins.oe_n            = oe_n;
  assign pins.wr_n            = wr_n;
  assign pins.prg_data        = drv;
  assign pins.prg_data_oe_n   = drv_n;
  assign pins.serial_reset_n  = rst_n;
  assign pins.sck             = sck;
  assign pins.serial_prog_in  = mosi;

endmodule // pfl_programmer

// File: verif/pfl_checker.sv
`timescale 1ns/100ps
module pfl_checker #(
  parameter int unsigned WRITE_CYCLES = 20,
  parameter int unsigned ERASE_CYCLES = 40
) (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic load_strobe,
  input wire logic oe_n,
  input wire logic wr_n,
  input wire logic dev_data_oe_n,
  input wire logic ready_busy_n,
  input wire logic serial_reset_n,
  input wire logic serial_prog_out
);
  localparam int WLRL = 250;
  localparam int DZ   = 62;
  int unsigned busy_cnt;

  // Long busy spans exceed any repetition count, so they are counted here
  always_ff @(posedge clock_in)
  begin
    busy_cnt <= (srst_in || ready_busy_n) ? 0 : busy_cnt + 1;
  end

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (srst_in);

  a_busy_after_write: assert property ($fell(wr_n) |-> ##[1:WLRL] !ready_busy_n)
    else $error("busy line did not fall after write strobe");
  a_busy_hold_span: assert property ($rose(ready_busy_n) |->
      (busy_cnt >= WRITE_CYCLES && busy_cnt <= WRITE_CYCLES + 4) ||
      (busy_cnt >= ERASE_CYCLES && busy_cnt <= ERASE_CYCLES + 4))
    else $error("busy span outside its window");
  a_release_after_oe: assert property ($rose(oe_n) |-> ##[1:DZ] dev_data_oe_n)
    else $error("data bus not released after read enable rose");
  a_drive_after_oe: assert property ($fell(oe_n) |-> ##[1:DZ] !dev_data_oe_n)
    else $error("data bus not driven during read");
  a_idle_no_drive: assert property (oe_n [*8] |-> dev_data_oe_n)
    else $error("device drives bus without read enable");
  a_write_when_ready: assert property ($fell(wr_n) |-> ready_busy_n)
    else $error("write strobe issued while busy");
  a_load_when_ready: assert property ($rose(load_strobe) |-> ready_busy_n)
    else $error("load issued while busy");
  a_busy_has_cause: assert property ($fell(ready_busy_n) && serial_reset_n |->
      !$past(wr_n, 2))
    else $error("busy started without write strobe");
  a_serial_out_idle: assert property (serial_reset_n [*4] |-> !serial_prog_out)
    else $error("serial output active outside session");

  cp_write: cover property ($fell(wr_n));
  cp_erase: cover property ($rose(ready_busy_n) && busy_cnt >= ERASE_CYCLES);
  cp_read: cover property (!oe_n && !dev_data_oe_n);
  cp_serial: cover property ($fell(serial_reset_n));
endmodule // pfl_checker

// File: verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import pfl_pkg::*;
  // Arbitrary identity values
  localparam logic [23:0] SIG = 24'h3c5a96;
  localparam logic [31:0] CAL = 32'h7d6e5f40;
  logic       clock_in, srst_in, req_valid, req_ready, done, busy, ser_en;
  logic       ses, sck_u, mosi_u, miso;
  pfl_op_t    req_op;
  logic [1:0] req_sel, s;
  logic [7:0] req_addr, req_data, rd_data, locks, f_lo, f_hi, f_ex;
  logic [7:0] m_lock, m_lo, m_hi, m_ex, b3, d;
  integer     seed = 42621;
  integer     r;
  int         error_cnt = 0;
  int         samples_checked = 0;

  pfl_if u_pfl_if ();
  pfl_device #(.WRITE_CYCLES(20), .ERASE_CYCLES(40), .FUSE_LOW_INIT(8'he1),
    .SIGNATURE(SIG), .CALIBRATION(CAL))
  u_pfl_device (.clock_in(clock_in), .srst_in(srst_in), .pins(u_pfl_if.dev),
    .lock_bits_out(locks), .fuse_low_out(f_lo), .fuse_high_out(f_hi),
    .fuse_ext_out(f_ex), .busy_out(busy), .serial_enabled_out(ser_en));
  pfl_programmer u_pfl_programmer (.clock_in(clock_in), .srst_in(srst_in),
    .pins(u_pfl_if.prg), .req_valid_in(req_valid), .req_op_in(req_op),
    .req_addr_in(req_addr), .req_data_in(req_data), .req_sel_in(req_sel),
    .req_ready_out(req_ready), .done_out(done), .rd_data_out(rd_data),
    .serial_session_in(ses), .sck_user_in(sck_u), .mosi_user_in(mosi_u), .miso_out(miso));
  // Checker defaults match the shortened busy spans given to the device
  pfl_checker u_pfl_checker (
    .clock_in(clock_in), .srst_in(srst_in), .load_strobe(u_pfl_if.load_strobe),
    .oe_n(u_pfl_if.oe_n), .wr_n(u_pfl_if.wr_n), .dev_data_oe_n(u_pfl_if.dev_data_oe_n),
    .ready_busy_n(u_pfl_if.ready_busy_n), .serial_reset_n(u_pfl_if.serial_reset_n),
    .serial_prog_out(u_pfl_if.serial_prog_out));

  initial
  begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end

  function automatic logic [7:0] exp_fuse(input logic [1:0] sel);
    case (sel)
      2'b00: return m_lo;
      2'b11: return m_hi;
      2'b10: return m_ex;
      default: return m_lock;
    endcase
  endfunction

  // Unused signature and calibration slots read as erased
  function automatic logic [7:0] exp_id(input logic [7:0] a, input logic cal);
    if (cal)
      return (a < 4) ? CAL[a*8 +: 8] : 8'hff;
    return (a < 3) ? SIG[a*8 +: 8] : 8'hff;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask

  task automatic conclude();
    $display("errors=%0d checks=%0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic run(input pfl_op_t o, input logic [7:0] a, input logic [7:0] dat,
                     input logic [1:0] sel);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 2000)
    begin
      @(negedge clock_in);
      n++;
    end
    @(posedge clock_in);
    req_valid <= 1'b1;
    req_op <= o;
    req_addr <= a;
    req_data <= dat;
    req_sel <= sel;
    @(posedge clock_in);
    req_valid <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 3000)
    begin
      @(negedge clock_in);
      n++;
    end
    chk({7'h0, done}, 8'h01);
  endtask

  // Phases of eight cycles keep well clear of the three-cycle minimum
  task automatic ser(input logic [31:0] w);
    for (int i = 31; i >= 0; i--)
    begin
      @(posedge clock_in);
      mosi_u <= w[i];
      repeat (8) @(posedge clock_in);
      @(negedge clock_in);
      if (i >= 8 && i < 16)
        b3[i-8] = miso;
      @(posedge clock_in);
      sck_u <= 1'b1;
      repeat (8) @(posedge clock_in);
      sck_u <= 1'b0;
    end
  endtask

  initial
  begin
    srst_in = 1'b1;
    req_valid = 1'b0;
    req_op = PFL_OP_FUSE_READ;
    req_addr = 8'h00;
    req_data = 8'h00;
    req_sel = 2'h0;
    ses = 1'b0;
    sck_u = 1'b0;
    mosi_u = 1'b0;
    m_lock = 8'hff;
    m_lo = 8'he1;
    m_hi = 8'hff;
    m_ex = 8'hff;
    repeat (3) @(posedge clock_in);
    srst_in <= 1'b0;
    @(negedge clock_in);
    chk(locks, m_lock);
    chk({f_lo ^ m_lo} | {f_hi ^ m_hi} | {f_ex ^ m_ex}, 8'h00);
    chk({6'h0, busy, u_pfl_if.ready_busy_n}, 8'h01);
    for (int k = 0; k < 4; k++)
    begin
      run(PFL_OP_FUSE_READ, 8'h00, 8'h00, k[1:0]);
      chk(rd_data, exp_fuse(k[1:0]));
    end
    for (int k = 0; k < 5; k++)
    begin
      run(PFL_OP_SIG_READ, k[7:0], 8'h00, 2'h0);
      chk(rd_data, exp_id(k[7:0], 1'b0));
      run(PFL_OP_CAL_READ, k[7:0], 8'h00, 2'h0);
      chk(rd_data, exp_id(k[7:0], 1'b1));
    end
    for (int k = 0; k < 8; k++)
    begin
      r = $random(seed);
      d = (k == 0) ? 8'hff : r[7:0];
      s = k[0] ? k[2:1] : r[9:8];
      if (k[0])
      begin
        run(PFL_OP_FUSE_WRITE, 8'h00, d, s);
        if (s[1]) m_ex = d; else if (s[0]) m_hi = d; else m_lo = d;
      end
      else
      begin
        run(PFL_OP_LOCK_WRITE, 8'h00, d, 2'h0);
        m_lock = m_lock & d;
      end
      chk(locks, m_lock);
      chk({f_lo ^ m_lo} | {f_hi ^ m_hi} | {f_ex ^ m_ex}, 8'h00);
      run(PFL_OP_FUSE_READ, 8'h00, 8'h00, s);
      chk(rd_data, exp_fuse(s));
    end
    // Fuse bytes now differ, so every select is told apart
    for (int k = 0; k < 4; k++)
    begin
      run(PFL_OP_FUSE_READ, 8'h00, 8'h00, k[1:0]);
      chk(rd_data, exp_fuse(k[1:0]));
    end
    @(posedge clock_in);
    ses <= 1'b1;
    repeat (8) @(posedge clock_in);
    ser(32'hac800000);
    repeat (60) @(negedge clock_in);
    chk({locks[7:1], busy}, {m_lock[7:1], 1'b0});
    ser(32'hac530000);
    chk(b3, 8'h53);
    chk({7'h0, ser_en}, 8'h01);
    ser(32'hac800000);
    repeat (100) @(negedge clock_in);
    m_lock = 8'hff;
    chk(locks, m_lock);
    @(posedge clock_in);
    ses <= 1'b0;
    repeat (8) @(negedge clock_in);
    chk({7'h0, ser_en}, 8'h00);
    run(PFL_OP_LOCK_WRITE, 8'h00, 8'h00, 2'h0);
    chk(locks, 8'h00);
    run(PFL_OP_CHIP_ERASE, 8'h00, 8'h00, 2'h0);
    chk(locks, 8'hff);
    conclude();
  end

  initial
  begin
    repeat (60000) @(posedge clock_in);
    error_cnt++;
    conclude();
  end
endmodule // tb_top
